// ===== verilog/fpxu_defs.svh
// Constants for the precision-expand unit: instruction fields and opcodes
`ifndef FPXU_DEFS_SVH
`define FPXU_DEFS_SVH
`define FPXU_OPC_HI        31
`define FPXU_OPC_LO        26
`define FPXU_DST_HI        25
`define FPXU_DST_LO        21
`define FPXU_SRC_HI        20
`define FPXU_SRC_LO        16
`define FPXU_SUB_HI        15
`define FPXU_SUB_LO        9
`define FPXU_MID_HI        8
`define FPXU_MID_LO        6
`define FPXU_LOW_HI        5
`define FPXU_LOW_LO        3
`define FPXU_TAIL_HI       2
`define FPXU_TAIL_LO       0
`define FPXU_PRIMARY_OPC   6'h08
`define FPXU_MID_FIELD     3'h4
`define FPXU_LOW_FIELD     3'h7
`define FPXU_TAIL_FIELD    3'h7
`define FPXU_SUB_HALF_L    7'h28
`define FPXU_SUB_HALF_R    7'h30
`define FPXU_SUB_BYTE_L    7'h38
`define FPXU_SUB_BYTE_LA   7'h39
`define FPXU_SUB_BYTE_R    7'h48
`define FPXU_SUB_BYTE_RA   7'h49
`endif

// ===== verilog/fpxu_pkg.sv
// Types shared by the precision-expand unit
package fpxu_pkg;
  typedef enum logic [6:0] {
    FPXU_OP_NONE   = 7'h01,
    FPXU_OP_HALF_L = 7'h02,
    FPXU_OP_HALF_R = 7'h04,
    FPXU_OP_BYTE_L = 7'h08,
    FPXU_OP_BYTE_LA = 7'h10,
    FPXU_OP_BYTE_R = 7'h20,
    FPXU_OP_BYTE_RA = 7'h40
  } fpxu_op_t;
endpackage : fpxu_pkg

// ===== verilog/fpxu_dec_if.sv
// Decoded operation carried from the decoder to the datapath
`timescale 1ns/1ps
interface fpxu_dec_if;
  import fpxu_pkg::*;
  fpxu_op_t op;
  logic     hit;
  modport dec (output op, output hit);
  modport dp  (input op, input hit);
endinterface : fpxu_dec_if

// ===== verilog/fpxu_decode.sv
// Instruction decoder for the precision-expand family
`timescale 1ns/1ps
`include "fpxu_defs.svh"
module fpxu_decode
  import fpxu_pkg::*;
(
  input  wire logic [31:0] instr_i,
  fpxu_dec_if.dec          dec
);
  logic [6:0] sub;
  logic       frame_ok;

  // Common frame: primary opcode, fixed middle and tail fields
  always_comb begin
    sub      = instr_i[`FPXU_SUB_HI:`FPXU_SUB_LO];
    frame_ok = (instr_i[`FPXU_OPC_HI:`FPXU_OPC_LO] == `FPXU_PRIMARY_OPC) &&
               (instr_i[`FPXU_MID_HI:`FPXU_MID_LO] == `FPXU_MID_FIELD) &&
               (instr_i[`FPXU_LOW_HI:`FPXU_LOW_LO] == `FPXU_LOW_FIELD) &&
               (instr_i[`FPXU_TAIL_HI:`FPXU_TAIL_LO] == `FPXU_TAIL_FIELD);
    dec.op   = FPXU_OP_NONE;
    if (frame_ok) begin
      unique case (sub)
        `FPXU_SUB_HALF_L:  dec.op = FPXU_OP_HALF_L;
        `FPXU_SUB_HALF_R:  dec.op = FPXU_OP_HALF_R;
        `FPXU_SUB_BYTE_L:  dec.op = FPXU_OP_BYTE_L;
        `FPXU_SUB_BYTE_LA: dec.op = FPXU_OP_BYTE_LA;
        `FPXU_SUB_BYTE_R:  dec.op = FPXU_OP_BYTE_R;
        `FPXU_SUB_BYTE_RA: dec.op = FPXU_OP_BYTE_RA;
        default:           dec.op = FPXU_OP_NONE;
      endcase
    end
    dec.hit = (dec.op != FPXU_OP_NONE);
  end
endmodule : fpxu_decode

// ===== verilog/fpxu_top.sv
// Precision-expand execution slice: decode, expand and register the result
// Notes on behaviour
// - Left-half expand writes source bits 31..16 then sixteen zero bits.
// - Right-half expand writes source bits 15..0 then sixteen zero bits.
// - Right-half expand decodes on 0110000, 100, 111 in bits 15..3.
// - Family uses opcode 001000, dest 25..21, source 20..16, tail 111.
// - Each Q15 lane is zero, source byte, then seven zero bits.
// - Left pair (0111000) takes bytes 31..24 and 23..16.
// - Left alternate (0111001) takes bytes 31..24 and 15..8.
// - Right pair (1001000) takes bytes 15..8 and 7..0.
// - Right alternate (1001001) takes bytes 23..16 and 7..0.
// - First selected byte lane goes high, second lane goes low.
// - No exception ever depends on operand data.
// - Without extension access, raise an exception and write nothing.
`timescale 1ns/1ps
`include "fpxu_defs.svh"
module fpxu_top
  import fpxu_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        issue_i,
  input  wire logic [31:0] instr_i,
  input  wire logic [31:0] src_data_i,
  input  wire logic        ext_access_ok_i,
  output logic             wr_en_o,
  output logic [4:0]       wr_addr_o,
  output logic [31:0]      wr_data_o,
  output logic             ext_fault_o,
  output logic             hit_o,
  output logic [4:0]       src_addr_o
);
  fpxu_dec_if dec_bus ();

  logic [31:0] result;
  logic [7:0]  byte_hi;
  logic [7:0]  byte_lo;
  logic [1:0][7:0]  lane_byte;
  logic [1:0][15:0] lane_q15;
  logic        next_wr_en;
  logic [4:0]  next_wr_addr;
  logic [31:0] next_wr_data;
  logic        next_ext_fault;
  logic        next_hit;
  logic [4:0]  next_src_addr;

  fpxu_decode u_decode (
    .instr_i (instr_i),
    .dec     (dec_bus.dec)
  );

  // Byte selection for the byte-to-Q15 forms
  always_comb begin
    byte_hi = 8'h00;
    byte_lo = 8'h00;
    unique case (dec_bus.op)
      FPXU_OP_BYTE_L: begin
        byte_hi = src_data_i[31:24];
        byte_lo = src_data_i[23:16];
      end
      FPXU_OP_BYTE_LA: begin
        byte_hi = src_data_i[31:24];
        byte_lo = src_data_i[15:8];
      end
      FPXU_OP_BYTE_R: begin
        byte_hi = src_data_i[15:8];
        byte_lo = src_data_i[7:0];
      end
      FPXU_OP_BYTE_RA: begin
        byte_hi = src_data_i[23:16];
        byte_lo = src_data_i[7:0];
      end
      default: begin
        byte_hi = 8'h00;
        byte_lo = 8'h00;
      end
    endcase
  end

  // Lane 1 takes the first selected byte, lane 0 the second
  assign lane_byte = {byte_hi, byte_lo};

  // One Q15 lane per selected byte: zero sign, byte, seven zeros
  for (genvar g = 0; g < 2; g++) begin : g_lane
    assign lane_q15[g] = {1'b0, lane_byte[g], 7'h00};
  end

  // Pure bit rearrangement; no data-dependent fault path exists
  always_comb begin
    unique case (dec_bus.op)
      FPXU_OP_HALF_L: result = {src_data_i[31:16], 16'h0000};
      FPXU_OP_HALF_R: result = {src_data_i[15:0], 16'h0000};
      FPXU_OP_NONE:   result = 32'h0000_0000;
      default:        result = lane_q15;
    endcase
  end

  // Write-back and access check
  always_comb begin
    next_hit       = issue_i && dec_bus.hit;
    next_wr_en     = next_hit && ext_access_ok_i;
    next_ext_fault = next_hit && !ext_access_ok_i;
    next_wr_addr   = instr_i[`FPXU_DST_HI:`FPXU_DST_LO];
    next_src_addr  = instr_i[`FPXU_SRC_HI:`FPXU_SRC_LO];
    next_wr_data   = next_wr_en ? result : 32'h0000_0000;
  end

  // Result stage, same timing as other simple ALU results
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_en_o     <= 1'b0;
      wr_addr_o   <= 5'h00;
      wr_data_o   <= 32'h0000_0000;
      ext_fault_o <= 1'b0;
      hit_o       <= 1'b0;
      src_addr_o  <= 5'h00;
    end else begin
      wr_en_o     <= next_wr_en;
      wr_addr_o   <= next_wr_addr;
      wr_data_o   <= next_wr_data;
      ext_fault_o <= next_ext_fault;
      hit_o       <= next_hit;
      src_addr_o  <= next_src_addr;
    end
  end
endmodule : fpxu_top

// ===== testbench/fpxu_top_sva.sv
// Checker for the precision-expand slice
`timescale 1ns/1ps
module fpxu_top_sva (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic        issue_i,
  input wire logic [31:0] instr_i,
  input wire logic [31:0] src_data_i,
  input wire logic        ext_access_ok_i,
  input wire logic        wr_en_o,
  input wire logic [4:0]  wr_addr_o,
  input wire logic [31:0] wr_data_o,
  input wire logic        ext_fault_o,
  input wire logic        hit_o,
  input wire logic [4:0]  src_addr_o
);
  logic [31:0] ps;
  logic        fam;
  logic        go;
  logic [6:0]  sc;
  logic        known;
  // Family frame match, access grant and sub code
  assign fam = issue_i && instr_i[31:26] == 6'h08 && instr_i[8:0] == 9'h13f;
  assign go = fam && ext_access_ok_i;
  assign sc = instr_i[15:9];
  // Sub codes that belong to the decoded family
  assign known = sc inside {7'h28, 7'h30, 7'h38, 7'h39, 7'h48, 7'h49};
  // Source value of the cycle before
  always_ff @(posedge sys_clk_i) ps <= src_data_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  half_l_a: assert property (go && sc == 7'h28 |=> wr_en_o && wr_data_o == {ps[31:16], 16'h0})
    else $error("left half expand");
  half_r_a: assert property (go && sc == 7'h30 |=> wr_en_o && wr_data_o == {ps[15:0], 16'h0})
    else $error("right half expand");
  pair_l_a: assert property (go && sc == 7'h38 |=> wr_data_o == {1'b0, ps[31:24], 8'h0, ps[23:16], 7'h0})
    else $error("left pair expand");
  alt_l_a: assert property (go && sc == 7'h39 |=> wr_data_o == {1'b0, ps[31:24], 8'h0, ps[15:8], 7'h0})
    else $error("left alternate expand");
  pair_r_a: assert property (go && sc == 7'h48 |=> wr_data_o == {1'b0, ps[15:8], 8'h0, ps[7:0], 7'h0})
    else $error("right pair expand");
  alt_r_a: assert property (go && sc == 7'h49 |=> wr_data_o == {1'b0, ps[23:16], 8'h0, ps[7:0], 7'h0})
    else $error("right alternate expand");
  denied_a: assert property (fam && known && !ext_access_ok_i |=> ext_fault_o && hit_o && !wr_en_o)
    else $error("denied access wrote");
  sub_miss_a: assert property (fam && !known |=> !hit_o && !wr_en_o && !ext_fault_o)
    else $error("unknown sub code hit");
  opc_miss_a: assert property (issue_i && instr_i[31:26] != 6'h08 |=> !hit_o && !wr_en_o && !ext_fault_o)
    else $error("foreign opcode hit");
  mid_miss_a: assert property (issue_i && instr_i[8:6] != 3'h4 |=> !hit_o && !wr_en_o)
    else $error("bad mid field hit");
  reg_addr_a: assert property (issue_i |=> wr_addr_o == $past(instr_i[25:21]) && src_addr_o == $past(instr_i[20:16]))
    else $error("register numbers wrong");
endmodule : fpxu_top_sva
bind fpxu_top fpxu_top_sva u_sva (.*);

// ===== testbench/fpxu_core_model.sv
// Core-side model: register file read port feeding the source operand
`timescale 1ns/1ps
module fpxu_core_model (
  input  wire logic [31:0] instr_i,
  output logic      [31:0] src_data_o
);
  logic [4:0] r;
  // Four distinct bytes per register, read by the source field
  assign r = instr_i[20:16];
  assign src_data_o = {3'h1, r, 3'h3, r, 3'h5, r, 3'h6, r};
endmodule : fpxu_core_model

// ===== testbench/fpxu_top_test.sv
// Self-checking bench for the precision-expand slice
`timescale 1ns/1ps
module fpxu_top_test;
  logic        clk, rst, issue, ok, wr_en, fault, hit;
  logic [31:0] instr, src, wr_data, s;
  logic [4:0]  wr_addr, src_addr;
  int          failures, tests_run, cyc;
  fpxu_core_model u_core (.instr_i(instr), .src_data_o(src));
  fpxu_top DUT (.sys_clk_i(clk), .rst_i(rst), .issue_i(issue), .instr_i(instr),
    .src_data_i(src), .ext_access_ok_i(ok), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
    .wr_data_o(wr_data), .ext_fault_o(fault), .hit_o(hit), .src_addr_o(src_addr));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // Expected result from the sub code and the source word
  function automatic logic [31:0] exp_of(input logic [6:0] c, input logic [31:0] v);
    logic [7:0] a;
    logic [7:0] b;
    a = (c == 7'h48) ? v[15:8] : (c == 7'h49) ? v[23:16] : v[31:24];
    b = (c == 7'h38) ? v[23:16] : (c == 7'h39) ? v[15:8] : v[7:0];
    if (c == 7'h28) return {v[31:16], 16'h0};
    if (c == 7'h30) return {v[15:0], 16'h0};
    return {1'b0, a, 8'h0, b, 7'h0};
  endfunction : exp_of
  // Issue one word, then let the answering edge land
  task send(input logic [5:0] op, input logic [6:0] c, input logic [8:0] tl,
            input logic [4:0] r, input logic en);
    @(posedge clk);
    issue <= 1'b1;
    instr <= {op, ~r, r, c, tl};
    ok <= en;
    @(posedge clk);
    s = src;
    issue <= 1'b0;
    #1;
  endtask : send
  // Every expand code, register 31 included
  task ops_scn;
    logic [6:0] codes [6];
    logic [4:0] r;
    codes = '{7'h28, 7'h30, 7'h38, 7'h39, 7'h48, 7'h49};
    foreach (codes[i]) begin
      r = 5'(31 - i * 5);
      send(6'h08, codes[i], 9'h13f, r, 1'b1);
      chk({24'h0, wr_en, hit, fault, wr_addr}, {24'h0, 3'b110, ~r});
      chk(wr_data, exp_of(codes[i], s));
      chk({27'h0, src_addr}, {27'h0, r});
    end
  endtask : ops_scn
  // Denied access, foreign opcode, bad mid field
  task refuse_scn;
    send(6'h08, 7'h38, 9'h13f, 5'd3, 1'b0);
    chk({29'h0, hit, fault, wr_en}, 32'h6);
    chk(wr_data, 32'h0);
    send(6'h08, 7'h58, 9'h13f, 5'd4, 1'b1);
    chk({29'h0, hit, fault, wr_en}, 32'h0);
    send(6'h09, 7'h38, 9'h13f, 5'd3, 1'b1);
    chk({29'h0, hit, fault, wr_en}, 32'h0);
    send(6'h08, 7'h30, 9'h0ff, 5'd2, 1'b1);
    chk({29'h0, hit, fault, wr_en}, 32'h0);
  endtask : refuse_scn
  // Mid-run reset clears outputs at once, then work resumes
  task reset_scn;
    send(6'h08, 7'h28, 9'h13f, 5'd9, 1'b1);
    chk(wr_data, exp_of(7'h28, s));
    rst <= 1'b1;
    #1;
    chk({19'h0, wr_en, hit, fault, wr_addr, src_addr}, 32'h0);
    chk(wr_data, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    send(6'h08, 7'h30, 9'h13f, 5'd9, 1'b1);
    chk(wr_data, exp_of(7'h30, s));
  endtask : reset_scn
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      failures++;
      print_verdict;
    end
  end
  initial begin
    {issue, ok, instr, failures, tests_run, cyc} = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    ops_scn;
    refuse_scn;
    reset_scn;
    print_verdict;
  end
endmodule : fpxu_top_test
